// ### hw/cal_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cal_if;
	import hib_pkg::*;

	logic  enable;
	logic  load;
	sec_t  load_sec;
	min_t  load_min;
	hour_t load_hour;
	sec_t  match_sec;
	min_t  match_min;
	hour_t match_hour;
	sec_t  sec;
	min_t  min;
	hour_t hour;
	logic  match;

	modport core (
		input  enable, load, load_sec, load_min, load_hour,
		input  match_sec, match_min, match_hour,
		output sec, min, hour, match
	);

	modport ctrl (
		output enable, load, load_sec, load_min, load_hour,
		output match_sec, match_min, match_hour,
		input  sec, min, hour, match
	);

endinterface

`default_nettype wire

// ### hw/calendar_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_tamper_calendar_regs.svh"

module calendar_core
	import hib_pkg::*;
#(
	parameter int unsigned SEC_TICKS = `HIB_TICKS_PER_SEC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic hib_tick,
	cal_if.core       cal
);
	logic  pre_busy;
	logic  sec_tick;
	sec_t  sec_q;
	sec_t  sec_d;
	min_t  min_q;
	min_t  min_d;
	hour_t hour_q;
	hour_t hour_d;
	logic  match_q;
	logic  match_d;

	// ==================================================
	// One-second prescaler on hibernation clock edges
	hib_edge_timer #(.COUNT(SEC_TICKS)) u_prescale (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (cal.enable && !pre_busy),
		.abort   (!cal.enable || cal.load),
		.tick    (hib_tick),
		.busy    (pre_busy),
		.done    (sec_tick)
	);

	// ==================================================
	// Time of day, kept in 24-hour form
	always_comb begin
		sec_d   = sec_q;
		min_d   = min_q;
		hour_d  = hour_q;
		match_d = 1'b0;
		if (cal.load) begin
			sec_d  = cal.load_sec;
			min_d  = cal.load_min;
			hour_d = cal.load_hour;
		end else if (sec_tick) begin
			sec_d = (sec_q >= `SEC_MAX) ? 6'h00 : sec_t'(sec_q + 6'h01);
			if (sec_q >= `SEC_MAX) begin
				min_d = (min_q >= `MIN_MAX) ? 6'h00 : min_t'(min_q + 6'h01);
				if (min_q >= `MIN_MAX) begin
					hour_d = (hour_q >= `HOUR_MAX) ? 5'h00 : hour_t'(hour_q + 5'h01);
				end
			end
			// Full-day compare, half-day flag folded into match_hour
			match_d = (sec_d == cal.match_sec) && (min_d == cal.match_min) &&
				(hour_d == cal.match_hour);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_q   <= 6'h00;
			min_q   <= 6'h00;
			hour_q  <= 5'h00;
			match_q <= 1'b0;
		end else begin
			sec_q   <= sec_d;
			min_q   <= min_d;
			hour_q  <= hour_d;
			match_q <= match_d;
		end
	end

	assign cal.sec   = sec_q;
	assign cal.min   = min_q;
	assign cal.hour  = hour_q;
	assign cal.match = match_q;

endmodule // calendar_core

`default_nettype wire

// ### hw/hib_edge_timer.sv
`timescale 1ns/1ps
`default_nettype none

module hib_edge_timer #(
	parameter int unsigned COUNT = 3
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic abort,
	input  wire logic tick,
	output logic      busy,
	output logic      done
);
	localparam int unsigned W = $clog2(COUNT + 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         done_q;
	logic         done_d;

	// ==================================================
	// Edge countdown
	always_comb begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (abort) begin
			cnt_d = '0;
		end else if (start) begin
			cnt_d = W'(COUNT);
		end else if (tick && cnt_q != '0) begin
			cnt_d  = cnt_q - W'(1);
			done_d = (cnt_q == W'(1));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = done_q;

endmodule // hib_edge_timer

`default_nettype wire

// ### hw/hib_pkg.sv
`default_nettype none
`include "hib_tamper_calendar_regs.svh"

package hib_pkg;

	typedef logic [5:0] sec_t;
	typedef logic [5:0] min_t;
	typedef logic [4:0] hour_t;
	typedef logic [3:0] log_cnt_t;
	typedef logic [3:0] mem_idx_t;
	typedef logic [1:0] tamper_mem_clear_sel_t;

	typedef enum logic [1:0] {
		TC_IDLE     = 2'b01,
		TC_CLEARING = 2'b10
	} tclr_state_t;

	function automatic hour_t to_hour12(input hour_t h24);
		hour_t h;
		h = (h24 >= `HOURS_HALF_DAY) ? hour_t'(h24 - `HOURS_HALF_DAY) : h24;
		if (h == 5'h00) begin
			h = `HOURS_HALF_DAY;
		end
		return h;
	endfunction

	function automatic hour_t from_hour12(input hour_t h12, input logic pm);
		hour_t h;
		h = (h12 == `HOURS_HALF_DAY) ? 5'h00 : h12;
		if (pm) begin
			h = hour_t'(h + `HOURS_HALF_DAY);
		end
		return h;
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

`default_nettype wire

// ### hw/hib_tamper_calendar_regs.svh
`ifndef HIB_TAMPER_CALENDAR_REGS_SVH
`define HIB_TAMPER_CALENDAR_REGS_SVH

// ==================================================
// Register offsets
`define OFF_HIB_CTL        8'h00
`define OFF_TAMPER_CTL     8'h04
`define OFF_TAMPER_LOG     8'h08
`define OFF_CAL_CTL        8'h0c
`define OFF_CAL_VAL        8'h10
`define OFF_CAL_MATCH      8'h14
`define OFF_INT_STATUS     8'h18
`define OFF_INT_MASK       8'h1c
`define OFF_MEM_BASE       8'h40
`define MEM_REGION_MASK    8'hc0
`define MEM_IDX_LSB        2
`define MEM_WORDS          16
`define MEM_HALF           8

// ==================================================
// Field positions
`define CTL_CLK_EN         0
`define CTL_WRC            31
`define TPC_ENABLE         0
`define TPC_CLEAR          4
`define TPC_TAMPER_MEM_CLEAR_SEL_LSB     8
`define TPC_BUSY           16
`define LOG_EVENT          0
`define LOG_CNT_LSB        8
`define CALC_ENABLE        0
`define CALC_H24           2
`define VAL_SEC_LSB        0
`define VAL_MIN_LSB        8
`define VAL_HOUR_LSB       16
`define VAL_PM             22
`define INT_TAMPER         0
`define INT_MATCH          1
`define INT_WRC            2

// ==================================================
// Encodings and reset values
`define TAMPER_MEM_CLEAR_SEL_NONE        2'h0
`define TAMPER_MEM_CLEAR_SEL_LOWER       2'h1
`define TAMPER_MEM_CLEAR_SEL_UPPER       2'h2
`define TAMPER_MEM_CLEAR_SEL_ALL         2'h3
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define WRC_RESET          1'b1
`define SEC_MAX            6'h3b
`define MIN_MAX            6'h3b
`define HOUR_MAX           5'h17
`define HOURS_HALF_DAY     5'h0c

// ==================================================
// Timing counts in hibernation clock edges
`define TAMPER_CLR_EDGES   3
`define CTL_XFER_EDGES     2
`define HIB_TICKS_PER_SEC  32768

`endif

// ### hw/hibernate_tamper_calendar.sv
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hib_tamper_calendar_regs.svh"

module hibernate_tamper_calendar
	import hib_pkg::*;
#(
	parameter int unsigned SEC_TICKS = `HIB_TICKS_PER_SEC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        hib_clk_in,
	input  wire logic        tamper_in,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	cal_if cal ();

	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic        aw_hs, w_hs, ar_hs, wr_fire, wr_ok, rd_ok;
	logic [7:0]  wa, ra;
	logic [31:0] wr_val, rd_val, wmask;

	logic        hib_clk_q, tamper_q, hib_tick, tamper_ev;
	logic        clk_en_q, clk_en_d, ctl_pend_q, ctl_pend_d, wrc_q, wrc_d;
	logic        ctl_start, ctl_done;
	logic        tp_en_q, tp_en_d;
	tamper_mem_clear_sel_t     tamper_mem_clear_sel_q, tamper_mem_clear_sel_d;
	tclr_state_t tc_state_q, tc_state_d;
	logic        tclr_start, tclr_done;
	logic        logged_q, logged_d;
	log_cnt_t    cnt_q, cnt_d, pend_q, pend_d;
	logic        cal_en_q, cal_en_d, h24_q, h24_d;
	logic [31:0] match_q, match_d;
	logic [2:0]  ist_q, ist_d, imask_q, imask_d;
	logic        irq_q, irq_d;
	logic [31:0] mem_q [`MEM_WORDS];
	logic [31:0] mem_d [`MEM_WORDS];
	hour_t       disp_hour;
	logic [31:0] cal_val;

	// ==================================================
	// Hibernation clock edges and tamper edges
	assign hib_tick  = hib_clk_in && !hib_clk_q;
	assign tamper_ev = tamper_in && !tamper_q && tp_en_q;

	hib_edge_timer #(.COUNT(`TAMPER_CLR_EDGES)) u_tclr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (tclr_start),
		.abort   (1'b0),
		.tick    (hib_tick),
		.busy    (),
		.done    (tclr_done)
	);

	hib_edge_timer #(.COUNT(`CTL_XFER_EDGES)) u_ctl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (ctl_start),
		.abort   (1'b0),
		.tick    (hib_tick),
		.busy    (),
		.done    (ctl_done)
	);

	calendar_core #(.SEC_TICKS(SEC_TICKS)) u_cal (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.hib_tick (hib_tick),
		.cal      (cal)
	);

	// ==================================================
	// Calendar hookup
	assign cal.enable    = cal_en_q && clk_en_q;
	assign cal.load      = wr_fire && wa == `OFF_CAL_VAL;
	assign cal.load_sec  = wr_val[`VAL_SEC_LSB +: $bits(sec_t)];
	assign cal.load_min  = wr_val[`VAL_MIN_LSB +: $bits(min_t)];
	assign cal.load_hour = h24_q ? wr_val[`VAL_HOUR_LSB +: $bits(hour_t)] :
		from_hour12(wr_val[`VAL_HOUR_LSB +: $bits(hour_t)], wr_val[`VAL_PM]);
	assign cal.match_sec = match_q[`VAL_SEC_LSB +: $bits(sec_t)];
	assign cal.match_min = match_q[`VAL_MIN_LSB +: $bits(min_t)];
	assign cal.match_hour = h24_q ? match_q[`VAL_HOUR_LSB +: $bits(hour_t)] :
		from_hour12(match_q[`VAL_HOUR_LSB +: $bits(hour_t)], match_q[`VAL_PM]);
	assign disp_hour = h24_q ? cal.hour : to_hour12(cal.hour);

	// Calendar value as software sees it
	always_comb begin
		cal_val = 32'h0000_0000;
		cal_val[`VAL_SEC_LSB +: $bits(sec_t)]   = cal.sec;
		cal_val[`VAL_MIN_LSB +: $bits(min_t)]   = cal.min;
		cal_val[`VAL_HOUR_LSB +: $bits(hour_t)] = disp_hour;
		cal_val[`VAL_PM] = (cal.hour >= `HOURS_HALF_DAY);
	end

	// ==================================================
	// AXI4-Lite handshakes
	assign aw_hs   = s_axi_awvalid && awready_q;
	assign w_hs    = s_axi_wvalid && wready_q;
	assign ar_hs   = s_axi_arvalid && arready_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wa      = {awaddr_q[7:2], 2'b00};
	assign ra      = {s_axi_araddr[7:2], 2'b00};
	assign wmask   = merge_bytes(32'h0000_0000, 32'hffff_ffff, wstrb_q);

	always_comb begin
		case (wa)
			`OFF_HIB_CTL:    wr_val = merge_bytes({31'h0, ctl_pend_q}, wdata_q, wstrb_q);
			`OFF_CAL_VAL:    wr_val = merge_bytes(cal_val, wdata_q, wstrb_q);
			`OFF_CAL_MATCH:  wr_val = merge_bytes(match_q, wdata_q, wstrb_q);
			default:         wr_val = merge_bytes(mem_q[wa[`MEM_IDX_LSB +: $bits(mem_idx_t)]],
				wdata_q, wstrb_q);
		endcase
		case (wa)
			`OFF_HIB_CTL, `OFF_TAMPER_CTL, `OFF_TAMPER_LOG, `OFF_CAL_CTL, `OFF_CAL_VAL,
			`OFF_CAL_MATCH, `OFF_INT_STATUS, `OFF_INT_MASK: wr_ok = 1'b1;
			default: wr_ok = ((wa & `MEM_REGION_MASK) == `OFF_MEM_BASE);
		endcase
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (ra)
			`OFF_HIB_CTL: begin
				rd_val[`CTL_CLK_EN] = clk_en_q;
				rd_val[`CTL_WRC]    = wrc_q;
			end
			`OFF_TAMPER_CTL: begin
				rd_val[`TPC_ENABLE] = tp_en_q;
				rd_val[`TPC_TAMPER_MEM_CLEAR_SEL_LSB +: $bits(tamper_mem_clear_sel_t)] = tamper_mem_clear_sel_q;
				rd_val[`TPC_BUSY]   = (tc_state_q == TC_CLEARING);
			end
			`OFF_TAMPER_LOG: begin
				rd_val[`LOG_EVENT] = logged_q;
				rd_val[`LOG_CNT_LSB +: $bits(log_cnt_t)] = cnt_q;
			end
			`OFF_CAL_CTL: begin
				rd_val[`CALC_ENABLE] = cal_en_q;
				rd_val[`CALC_H24]    = h24_q;
			end
			`OFF_CAL_VAL:    rd_val = cal_val;
			`OFF_CAL_MATCH:  rd_val = match_q;
			`OFF_INT_STATUS: rd_val[2:0] = ist_q;
			`OFF_INT_MASK:   rd_val[2:0] = imask_q;
			default: begin
				rd_ok = ((ra & `MEM_REGION_MASK) == `OFF_MEM_BASE);
				if (rd_ok) begin
					rd_val = mem_q[ra[`MEM_IDX_LSB +: $bits(mem_idx_t)]];
				end
			end
		endcase
	end

	always_comb begin
		aw_have_d = aw_have_q || aw_hs;
		w_have_d  = w_have_q || w_hs;
		awaddr_d  = aw_hs ? s_axi_awaddr : awaddr_q;
		wdata_d   = w_hs ? s_axi_wdata : wdata_q;
		wstrb_d   = w_hs ? s_axi_wstrb : wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		arready_d = arready_q;
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (ar_hs) begin
			rvalid_d  = 1'b1;
			arready_d = 1'b0;
			rdata_d   = rd_val;
			rresp_d   = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d  = !w_have_d && !bvalid_d;
		// Raise read ready after reset
		arready_d = arready_d || (!rvalid_d && !arready_q);
	end

	// ==================================================
	// Control, tamper, calendar and interrupt state
	always_comb begin
		clk_en_d   = clk_en_q;
		ctl_pend_d = ctl_pend_q;
		wrc_d      = wrc_q;
		ctl_start  = 1'b0;
		tp_en_d    = tp_en_q;
		tamper_mem_clear_sel_d   = tamper_mem_clear_sel_q;
		tc_state_d = tc_state_q;
		tclr_start = 1'b0;
		logged_d   = logged_q;
		cnt_d      = cnt_q;
		pend_d     = pend_q;
		cal_en_d   = cal_en_q;
		h24_d      = h24_q;
		match_d    = match_q;
		ist_d      = ist_q;
		imask_d    = imask_q;
		mem_d      = mem_q;
		if (wr_fire) begin
			case (wa)
				`OFF_HIB_CTL: begin
					ctl_pend_d = wr_val[`CTL_CLK_EN];
					wrc_d      = 1'b0;
					ctl_start  = 1'b1;
				end
				`OFF_TAMPER_CTL: begin
					if (wstrb_q[0]) begin
						tp_en_d = wdata_q[`TPC_ENABLE];
						if (wdata_q[`TPC_CLEAR] && tc_state_q == TC_IDLE) begin
							tclr_start = 1'b1;
						end
					end
					if (wstrb_q[1]) begin
						tamper_mem_clear_sel_d = wdata_q[`TPC_TAMPER_MEM_CLEAR_SEL_LSB +: $bits(tamper_mem_clear_sel_t)];
					end
				end
				`OFF_CAL_CTL: begin
					if (wstrb_q[0]) begin
						cal_en_d = wdata_q[`CALC_ENABLE];
						h24_d    = wdata_q[`CALC_H24];
					end
				end
				`OFF_CAL_MATCH:  match_d = wr_val;
				`OFF_INT_STATUS: ist_d   = ist_q & ~wmask[2:0];
				`OFF_INT_MASK:   imask_d = (imask_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
				default: begin
					if ((wa & `MEM_REGION_MASK) == `OFF_MEM_BASE) begin
						mem_d[wa[`MEM_IDX_LSB +: $bits(mem_idx_t)]] = wr_val;
					end
				end
			endcase
		end
		if (ctl_done) begin
			clk_en_d = ctl_pend_q;
			// A restarted transfer keeps write complete low
			wrc_d    = !ctl_start;
		end
		case (tc_state_q)
			TC_IDLE: begin
				if (tclr_start) begin
					tc_state_d = TC_CLEARING;
					pend_d     = tamper_ev ? 4'h1 : 4'h0;
				end else if (tamper_ev) begin
					logged_d = 1'b1;
					cnt_d    = (cnt_q == 4'hf) ? cnt_q : log_cnt_t'(cnt_q + 4'h1);
				end
			end
			TC_CLEARING: begin
				if (tamper_ev && pend_q != 4'hf) begin
					pend_d = log_cnt_t'(pend_q + 4'h1);
				end
				if (tclr_done) begin
					tc_state_d = TC_IDLE;
					cnt_d      = pend_d;
					logged_d   = (pend_d != 4'h0);
					pend_d     = 4'h0;
				end
			end
			default: tc_state_d = TC_IDLE;
		endcase
		if (tamper_ev) begin
			for (int i = 0; i < `MEM_WORDS; i++) begin
				if (tamper_mem_clear_sel_q == `TAMPER_MEM_CLEAR_SEL_ALL ||
					(tamper_mem_clear_sel_q == `TAMPER_MEM_CLEAR_SEL_LOWER && i < `MEM_HALF) ||
					(tamper_mem_clear_sel_q == `TAMPER_MEM_CLEAR_SEL_UPPER && i >= `MEM_HALF)) begin
					mem_d[i] = 32'h0000_0000;
				end
			end
		end
		ist_d[`INT_TAMPER] = ist_d[`INT_TAMPER] || tamper_ev;
		ist_d[`INT_MATCH]  = ist_d[`INT_MATCH] || cal.match;
		ist_d[`INT_WRC]    = ist_d[`INT_WRC] || ctl_done;
		irq_d = |(ist_d & imask_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
			rresp_q   <= `RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
			bvalid_q  <= bvalid_d;
			rvalid_q  <= rvalid_d;
			bresp_q   <= bresp_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hib_clk_q  <= 1'b0;
			tamper_q   <= 1'b0;
			clk_en_q   <= 1'b0;
			ctl_pend_q <= 1'b0;
			wrc_q      <= `WRC_RESET;
			tp_en_q    <= 1'b0;
			tamper_mem_clear_sel_q   <= `TAMPER_MEM_CLEAR_SEL_NONE;
			tc_state_q <= TC_IDLE;
			logged_q   <= 1'b0;
			cnt_q      <= 4'h0;
			pend_q     <= 4'h0;
			cal_en_q   <= 1'b0;
			h24_q      <= 1'b0;
			match_q    <= 32'h0000_0000;
			ist_q      <= 3'h0;
			imask_q    <= 3'h0;
			irq_q      <= 1'b0;
			for (int i = 0; i < `MEM_WORDS; i++) begin
				mem_q[i] <= 32'h0000_0000;
			end
		end else begin
			hib_clk_q  <= hib_clk_in;
			tamper_q   <= tamper_in;
			clk_en_q   <= clk_en_d;
			ctl_pend_q <= ctl_pend_d;
			wrc_q      <= wrc_d;
			tp_en_q    <= tp_en_d;
			tamper_mem_clear_sel_q   <= tamper_mem_clear_sel_d;
			tc_state_q <= tc_state_d;
			logged_q   <= logged_d;
			cnt_q      <= cnt_d;
			pend_q     <= pend_d;
			cal_en_q   <= cal_en_d;
			h24_q      <= h24_d;
			match_q    <= match_d;
			ist_q      <= ist_d;
			imask_q    <= imask_d;
			irq_q      <= irq_d;
			mem_q      <= mem_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign irq           = irq_q;

endmodule // hibernate_tamper_calendar

`default_nettype wire

// ### verif/hibernate_tamper_calendar_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Bus and interrupt checks
module hib_tcal_chk
	import hib_pkg::*;
#(
	parameter int unsigned SEC_TICKS = 32768
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two cycles after handshake");
	chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("address ready during write");
	chk_w_busy: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready [*2])
		else $error("data ready during write");
	chk_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rresp == (($past(s_axi_araddr[7]) || $past(s_axi_araddr[7:5]) == 3'h1) ? 2'h2 : 2'h0))
		else $error("read response code wrong");
	chk_reset_idle: assert property ($rose(aresetn) |-> !irq && !s_axi_awready && !s_axi_bvalid
		&& !s_axi_rvalid)
		else $error("outputs active at reset release");
endmodule // hib_tcal_chk

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import hib_pkg::*;
	localparam int unsigned SEC_TICKS = 4;
	logic        aclk, irq;
	logic        aresetn = 1'b0, hib_clk_in = 1'b0, tamper_in = 1'b0;
	logic [3:0]  hdiv = 4'h0, s_axi_wstrb = 4'hf;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
	int          failures = 0, total_checks = 0, cyc = 0, hib_edges = 0;

	hibernate_tamper_calendar #(.SEC_TICKS(SEC_TICKS)) uut (.aclk, .aresetn, .hib_clk_in,
		.tamper_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq);

	// ==================================================
	// Clocks and timeout
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		hdiv <= hdiv + 4'h1;
		hib_clk_in <= hdiv[3];
		cyc++;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end
	always @(posedge hib_clk_in) hib_edges++;

	// ==================================================
	// Bus and compare tasks
	task automatic print_verdict;
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_data, e);
	endtask

	task automatic tp;
		@(posedge aclk);
		tamper_in <= 1'b1;
		repeat (2) @(posedge aclk);
		tamper_in <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic hib_wait(input int n);
		repeat (n) @(posedge hib_clk_in);
		repeat (5) @(posedge aclk);
	endtask

	// ==================================================
	// Scenarios
	task automatic t_hib_control_reg;
		rc(8'h00, 32'h80000000);
		rd(8'h20);
		chk({rd_data[29:0], rd_resp}, 32'h2);
		wr(8'h80, 32'h1);
		chk({30'h0, wr_resp}, 32'h2);
		wr(8'h1c, 32'h7);
		hib_wait(1);
		wr(8'h00, 32'h1);
		rc(8'h00, 32'h0);
		for (int i = 0; i < 40 && !rd_data[31]; i++) rd(8'h00);
		chk(rd_data, 32'h80000001);
		rc(8'h18, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr(8'h18, 32'h4);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_tamper;
		for (int s = 0; s < 4; s++) begin
			wr(8'h40, 32'ha5a5a5a5);
			wr(8'h7c, 32'h5a5a5a5a);
			wr(8'h04, {22'h0, s[1:0], 8'h01});
			tp();
			rc(8'h40, s[0] ? 32'h0 : 32'ha5a5a5a5);
			rc(8'h7c, s[1] ? 32'h0 : 32'h5a5a5a5a);
		end
		rc(8'h08, 32'h401);
		rc(8'h18, 32'h1);
	endtask

	task automatic t_clear;
		int n;
		@(posedge hib_clk_in);
		@(posedge aclk);
		n = hib_edges;
		wr(8'h04, 32'h311);
		rc(8'h04, 32'h10301);
		tp();
		for (int i = 0; i < 40 && rd_data[16]; i++) rd(8'h04);
		chk(32'(hib_edges - n), 32'h3);
		rc(8'h08, 32'h101);
		wr(8'h50, 32'h0);
		wr(8'h04, 32'h311);
		hib_wait(4);
		rc(8'h08, 32'h0);
		wr(8'h18, 32'h7);
	endtask

	task automatic t_cal;
		wr(8'h0c, 32'h1);
		wr(8'h14, 32'h000c0000);
		hib_wait(1);
		wr(8'h10, 32'h000b3b3b);
		hib_wait(4);
		rc(8'h10, 32'h004c0000);
		rc(8'h18, 32'h0);
		wr(8'h14, 32'h004c0001);
		hib_wait(4);
		rc(8'h18, 32'h2);
		wr(8'h0c, 32'h5);
		hib_wait(1);
		wr(8'h10, 32'h00173b3b);
		rc(8'h10, 32'h00573b3b);
		hib_wait(4);
		rc(8'h10, 32'h0);
		rc(8'h50, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_hib_control_reg();
		t_tamper();
		t_clear();
		t_cal();
		print_verdict();
	end
endmodule // testbench

bind hibernate_tamper_calendar hib_tcal_chk #(.SEC_TICKS(SEC_TICKS)) u_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .irq);

`default_nettype wire
